// ---- design/dcr_defs.vh ----
// Offsets, field positions, reset values and widths of the reload down-counter
`ifndef DCR_DEFS_VH
`define DCR_DEFS_VH

// ==========================================================
// Word offsets on the processor memory bus
`define DCR_ADDR_W            3
`define DCR_OFF_COUNT_LOW     3'h0
`define DCR_OFF_COUNT_HIGH    3'h1
`define DCR_OFF_PERIOD_LOW    3'h2
`define DCR_OFF_PERIOD_HIGH   3'h3
`define DCR_OFF_CONTROL       3'h4
`define DCR_OFF_RESERVED      3'h5
`define DCR_OFF_PRESCALE_LOW  3'h6
`define DCR_OFF_PRESCALE_HIGH 3'h7

// ==========================================================
// Control word bit positions
`define DCR_BIT_ZERO_FLAG     15
`define DCR_BIT_IRQ_ENABLE    14
`define DCR_BIT_FREE          11
`define DCR_BIT_SOFT          10
`define DCR_BIT_RELOAD        5
`define DCR_BIT_HALT_CTRL     4

// ==========================================================
// Prescale word fields
`define DCR_PRE_DIV_MSB       7
`define DCR_PRE_DIV_LSB       0
`define DCR_PRE_CNT_MSB       15
`define DCR_PRE_CNT_LSB       8

// ==========================================================
// Reset values
`define DCR_RST_COUNT_LOW     16'hffff
`define DCR_RST_COUNT_HIGH    16'h0000
`define DCR_RST_PERIOD_LOW    16'hffff
`define DCR_RST_PERIOD_HIGH   16'h0000
`define DCR_RST_DIVIDE        8'h00
`define DCR_RST_PRESCALE      16'h0000
`define DCR_ZERO_WORD         16'h0000
`define DCR_COUNT_ONE         32'h00000001
`define DCR_COUNT_ZERO        32'h00000000

`endif

// ---- design/dcr_prescaler.v ----
// Prescale counter that emits one tick every divide-down plus one cycles
`timescale 1ns/1ns
`default_nettype none

module dcr_prescaler #(
  parameter WIDTH = 16
) (
  input  wire             core_clk,
  input  wire             rst,
  input  wire             enable,
  input  wire             load,
  input  wire [WIDTH-1:0] divideDown,
  output reg  [WIDTH-1:0] prescaleCount,
  output wire             tick
);

  // ==========================================================
  // Tick
  // Combinational so the main count moves on the same edge as the reload
  assign tick = enable && !load && (prescaleCount == {WIDTH{1'b0}});

  // ==========================================================
  // Counter
  always @(posedge core_clk) begin
    if (rst) begin
      prescaleCount <= {WIDTH{1'b0}};
    end else if (load) begin
      prescaleCount <= divideDown;
    end else if (tick) begin
      prescaleCount <= divideDown;
    end else if (enable) begin
      prescaleCount <= prescaleCount - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

// ---- design/dcr_down_counter.v ----
// Reload down-counter with prescaler, zero flag, pulse interrupt and debug halt modes
// Notes on behaviour
// - Count held as low and high halves
// - Decrement every divide-down plus one cycles
// - At zero, reload count from period
// - Period low and high readable and writable
// - Interrupt event each time count reaches zero
// - Zero flag sticky, write one clears
// - Interrupt only while enable bit set
// - Breakpoint modes: hard, soft, free run
// - Free bit ignores soft bit, keeps counting
// - Soft stop still raises zero event first
// - Reload strobe loads count and prescaler
// - Reload strobe always reads zero
// - Halt bit stops counting; resets running
// - Count and period low halves reset ones, high halves zero
// - Prescaler reloads cycle after reaching zero
// - Prescale count read-only, resets to zero
// - Everything runs on the core clock
// - Interrupt output is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
`include "dcr_defs.vh"

module dcr_down_counter #(
  parameter COUNT_W  = 32,
  parameter HALF_W   = 16,
  parameter DIVIDE_W = 8
) (
  input  wire                   core_clk,
  input  wire                   rst,
  input  wire [`DCR_ADDR_W-1:0] busAddr,
  input  wire                   busWrite,
  input  wire                   busRead,
  input  wire [HALF_W-1:0]      busWdata,
  output reg  [HALF_W-1:0]      busRdata,
  output reg                    busRvalid,
  input  wire                   debugHalt,
  output reg                    zeroIrq
);

  // ==========================================================
  // Decode helpers
  function sel;
    input [`DCR_ADDR_W-1:0] addr;
    input [`DCR_ADDR_W-1:0] offset;
    input                   strobe;
    begin
      sel = strobe && (addr == offset);
    end
  endfunction

  // ==========================================================
  // Storage
  reg  [HALF_W-1:0]     countLow;
  reg  [HALF_W-1:0]     countHigh;
  reg  [HALF_W-1:0]     periodLow;
  reg  [HALF_W-1:0]     periodHigh;
  reg  [DIVIDE_W-1:0]   divideDownLow;
  reg  [DIVIDE_W-1:0]   divideDownHigh;
  reg                   zeroFlag;
  reg                   zeroIrqEnable;
  reg                   freeRun;
  reg                   softStop;
  reg                   haltCtrl;
  reg                   emuStopped;

  wire [COUNT_W-1:0]    count;
  wire [COUNT_W-1:0]    period;
  wire [2*DIVIDE_W-1:0] divideDown;
  wire [2*DIVIDE_W-1:0] prescaleCount;
  wire [DIVIDE_W-1:0]   prescaleCountLow;
  wire [DIVIDE_W-1:0]   prescaleCountHigh;
  wire                  running;
  wire                  tick;
  wire                  zeroEvent;
  wire                  reloadStrobe;
  wire                  wrCountLow;
  wire                  wrCountHigh;
  wire                  wrPeriodLow;
  wire                  wrPeriodHigh;
  wire                  wrControl;
  wire                  wrPrescaleLow;
  wire                  wrPrescaleHigh;
  reg  [COUNT_W-1:0]    next_count;
  reg  [HALF_W-1:0]     next_rdata;

  assign count      = {countHigh, countLow};
  assign period     = {periodHigh, periodLow};
  assign divideDown = {divideDownHigh, divideDownLow};

  assign prescaleCountLow  = prescaleCount[DIVIDE_W-1:0];
  assign prescaleCountHigh = prescaleCount[2*DIVIDE_W-1:DIVIDE_W];

  // ==========================================================
  // Write decode
  assign wrCountLow     = sel(busAddr, `DCR_OFF_COUNT_LOW, busWrite);
  assign wrCountHigh    = sel(busAddr, `DCR_OFF_COUNT_HIGH, busWrite);
  assign wrPeriodLow    = sel(busAddr, `DCR_OFF_PERIOD_LOW, busWrite);
  assign wrPeriodHigh   = sel(busAddr, `DCR_OFF_PERIOD_HIGH, busWrite);
  assign wrControl      = sel(busAddr, `DCR_OFF_CONTROL, busWrite);
  assign wrPrescaleLow  = sel(busAddr, `DCR_OFF_PRESCALE_LOW, busWrite);
  assign wrPrescaleHigh = sel(busAddr, `DCR_OFF_PRESCALE_HIGH, busWrite);

  // Strobe acts in the write cycle only, nothing is stored
  assign reloadStrobe = wrControl && busWdata[`DCR_BIT_RELOAD];

  // ==========================================================
  // Run control
  // Debug stop only holds while the processor is halted
  assign running = !haltCtrl && !emuStopped;

  always @(posedge core_clk) begin
    if (rst) begin
      emuStopped <= 1'b0;
    end else if (!debugHalt || freeRun) begin
      emuStopped <= 1'b0;
    end else if (tick && (!softStop || zeroEvent)) begin
      emuStopped <= 1'b1;
    end
  end

  // ==========================================================
  // Prescaler
  dcr_prescaler #(
    .WIDTH         (2*DIVIDE_W)
  ) u_prescaler (
    .core_clk      (core_clk),
    .rst           (rst),
    .enable        (running),
    .load          (reloadStrobe),
    .divideDown    (divideDown),
    .prescaleCount (prescaleCount),
    .tick          (tick)
  );

  // ==========================================================
  // Main count
  // Reaching zero is the one-to-zero step; a count written to zero raises nothing
  assign zeroEvent = tick && (count == `DCR_COUNT_ONE);

  always @* begin
    next_count = count;
    if (tick) begin
      if (count == `DCR_COUNT_ZERO) begin
        next_count = period;
      end else begin
        next_count = count - `DCR_COUNT_ONE;
      end
    end
    if (reloadStrobe) begin
      next_count = period;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      countLow <= `DCR_RST_COUNT_LOW;
    end else if (wrCountLow) begin
      countLow <= busWdata;
    end else begin
      countLow <= next_count[HALF_W-1:0];
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      countHigh <= `DCR_RST_COUNT_HIGH;
    end else if (wrCountHigh) begin
      countHigh <= busWdata;
    end else begin
      countHigh <= next_count[COUNT_W-1:HALF_W];
    end
  end

  // ==========================================================
  // Period
  always @(posedge core_clk) begin
    if (rst) begin
      periodLow <= `DCR_RST_PERIOD_LOW;
    end else if (wrPeriodLow) begin
      periodLow <= busWdata;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      periodHigh <= `DCR_RST_PERIOD_HIGH;
    end else if (wrPeriodHigh) begin
      periodHigh <= busWdata;
    end
  end

  // ==========================================================
  // Divide-down
  // Only the divide field is writable; the prescale count half is ignored
  always @(posedge core_clk) begin
    if (rst) begin
      divideDownLow <= `DCR_RST_DIVIDE;
    end else if (wrPrescaleLow) begin
      divideDownLow <= busWdata[`DCR_PRE_DIV_MSB:`DCR_PRE_DIV_LSB];
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      divideDownHigh <= `DCR_RST_DIVIDE;
    end else if (wrPrescaleHigh) begin
      divideDownHigh <= busWdata[`DCR_PRE_DIV_MSB:`DCR_PRE_DIV_LSB];
    end
  end

  // ==========================================================
  // Control word
  always @(posedge core_clk) begin
    if (rst) begin
      zeroIrqEnable <= 1'b0;
      freeRun       <= 1'b0;
      softStop      <= 1'b0;
      haltCtrl      <= 1'b0;
    end else if (wrControl) begin
      zeroIrqEnable <= busWdata[`DCR_BIT_IRQ_ENABLE];
      freeRun       <= busWdata[`DCR_BIT_FREE];
      softStop      <= busWdata[`DCR_BIT_SOFT];
      haltCtrl      <= busWdata[`DCR_BIT_HALT_CTRL];
    end
  end

  // Set beats a same-cycle clear so no zero crossing is lost
  always @(posedge core_clk) begin
    if (rst) begin
      zeroFlag <= 1'b0;
    end else if (zeroEvent) begin
      zeroFlag <= 1'b1;
    end else if (wrControl && busWdata[`DCR_BIT_ZERO_FLAG]) begin
      zeroFlag <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt
  always @(posedge core_clk) begin
    if (rst) begin
      zeroIrq <= 1'b0;
    end else begin
      zeroIrq <= zeroEvent && zeroIrqEnable;
    end
  end

  // ==========================================================
  // Read path
  always @* begin
    next_rdata = `DCR_ZERO_WORD;
    case (busAddr)
      `DCR_OFF_COUNT_LOW: begin
        next_rdata = countLow;
      end
      `DCR_OFF_COUNT_HIGH: begin
        next_rdata = countHigh;
      end
      `DCR_OFF_PERIOD_LOW: begin
        next_rdata = periodLow;
      end
      `DCR_OFF_PERIOD_HIGH: begin
        next_rdata = periodHigh;
      end
      `DCR_OFF_CONTROL: begin
        next_rdata[`DCR_BIT_ZERO_FLAG]  = zeroFlag;
        next_rdata[`DCR_BIT_IRQ_ENABLE] = zeroIrqEnable;
        next_rdata[`DCR_BIT_FREE]       = freeRun;
        next_rdata[`DCR_BIT_SOFT]       = softStop;
        next_rdata[`DCR_BIT_RELOAD]     = 1'b0;
        next_rdata[`DCR_BIT_HALT_CTRL]  = haltCtrl;
      end
      `DCR_OFF_PRESCALE_LOW: begin
        next_rdata[`DCR_PRE_DIV_MSB:`DCR_PRE_DIV_LSB] = divideDownLow;
        next_rdata[`DCR_PRE_CNT_MSB:`DCR_PRE_CNT_LSB] = prescaleCountLow;
      end
      `DCR_OFF_PRESCALE_HIGH: begin
        next_rdata[`DCR_PRE_DIV_MSB:`DCR_PRE_DIV_LSB] = divideDownHigh;
        next_rdata[`DCR_PRE_CNT_MSB:`DCR_PRE_CNT_LSB] = prescaleCountHigh;
      end
      default: begin
        next_rdata = `DCR_ZERO_WORD;
      end
    endcase
  end

  // Registered so the read data is stable for a whole cycle
  always @(posedge core_clk) begin
    if (rst) begin
      busRdata  <= `DCR_ZERO_WORD;
      busRvalid <= 1'b0;
    end else begin
      busRvalid <= busRead;
      if (busRead) begin
        busRdata <= next_rdata;
      end
    end
  end

endmodule

`default_nettype wire

// ---- tb/dcr_checker_asserts.sv ----
// Port checker for the reload down-counter
`timescale 1ns/1ns
`default_nettype none
`include "dcr_defs.vh"
module dcr_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [2:0]  busAddr,
  input wire logic        busWrite,
  input wire logic        busRead,
  input wire logic [15:0] busWdata,
  input wire logic [15:0] busRdata,
  input wire logic        busRvalid,
  input wire logic        debugHalt,
  input wire logic        zeroIrq
);
  // ==========
  // Shadow of enable and halt bits
  logic ien;
  logic hlt;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ien <= 1'b0;
      hlt <= 1'b0;
    end else if (busWrite && busAddr == `DCR_OFF_CONTROL) begin
      ien <= busWdata[14];
      hlt <= busWdata[4];
    end
  end
  // ==========
  // Properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence rdCtl;
    busRead && busAddr == `DCR_OFF_CONTROL;
  endsequence
  sequence rdRsv;
    busRead && busAddr == `DCR_OFF_RESERVED;
  endsequence
  AST_RVALID: assert property (busRead |=> busRvalid)
    else $error("read not answered");
  AST_NOSPUR: assert property (busRvalid |-> $past(busRead))
    else $error("valid without read");
  AST_HOLD: assert property ($changed(busRdata) |-> busRvalid)
    else $error("read data moved");
  AST_CTLRSV: assert property (rdCtl |=> (busRdata & 16'h33ef) == 16'h0000)
    else $error("reserved or reload bit read high");
  AST_IDX5: assert property (rdRsv |=> busRdata == 16'h0000)
    else $error("reserved word not zero");
  AST_PULSE: assert property (zeroIrq |=> !zeroIrq)
    else $error("irq longer than a cycle");
  AST_IEN: assert property (zeroIrq |-> $past(ien))
    else $error("irq while disabled");
  AST_HALT: assert property (zeroIrq |-> !$past(hlt))
    else $error("irq while halted");
endmodule
bind dcr_down_counter dcr_checker u_chk (
  .core_clk(core_clk), .rst(rst), .busAddr(busAddr), .busWrite(busWrite),
  .busRead(busRead), .busWdata(busWdata), .busRdata(busRdata),
  .busRvalid(busRvalid), .debugHalt(debugHalt), .zeroIrq(zeroIrq));
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the reload down-counter
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        core_clk;
  logic        rst;
  logic [2:0]  busAddr;
  logic        busWrite;
  logic        busRead;
  logic [15:0] busWdata;
  logic [15:0] busRdata;
  logic        busRvalid;
  logic        debugHalt;
  logic        zeroIrq;
  integer      mismatches;
  integer      checks;
  integer      seed;
  integer      i;
  integer      n;
  logic [15:0] r;
  logic [15:0] q;
  logic [15:0] p;
  logic [15:0] d;
  dcr_down_counter dut (
    .core_clk(core_clk), .rst(rst), .busAddr(busAddr), .busWrite(busWrite),
    .busRead(busRead), .busWdata(busWdata), .busRdata(busRdata),
    .busRvalid(busRvalid), .debugHalt(debugHalt), .zeroIrq(zeroIrq));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ==========
  // Tasks
  task results;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks = checks + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Extra idle edge so no strobe is assigned twice in one step
  task wr(input logic [2:0] a, input logic [15:0] v);
    busAddr <= a;
    busWdata <= v;
    busWrite <= 1'b1;
    @(posedge core_clk);
    busWrite <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [2:0] a, output logic [15:0] v);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge core_clk);
    busRead <= 1'b0;
    @(posedge core_clk);
    v = busRdata;
  endtask
  task rdc(input logic [2:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(v, e);
  endtask
  task waitIrq(output integer c);
    c = 0;
    do begin
      @(posedge core_clk);
      c = c + 1;
      if (c > 400) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t no irq within limit", $time);
        results();
      end
    end while (zeroIrq !== 1'b1);
  endtask
  function automatic logic [15:0] expGap(input logic [15:0] pp, input logic [15:0] dd);
    return (pp + 16'h1) * (dd + 16'h1);
  endfunction
  // ==========
  // Scenarios
  initial begin
    seed = 63320;
    mismatches = 0;
    checks = 0;
    rst = 1'b1;
    busAddr = 3'h0;
    busWrite = 1'b0;
    busRead = 1'b0;
    busWdata = 16'h0000;
    debugHalt = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rdc(3'h0, 16'hffff);
    for (i = 1; i < 8; i++) rdc(i[2:0], i == 2 ? 16'hffff : 16'h0000);
    repeat (3) begin
      {q, r} = $random(seed);
      wr(3'h2, r);
      wr(3'h3, q);
      rdc(3'h2, r);
      rdc(3'h3, q);
    end
    wr(3'h4, 16'h33ff);
    rdc(3'h4, 16'h0010);
    rdc(3'h0, r);
    rdc(3'h1, q);
    wr(3'h0, 16'h1234);
    rdc(3'h0, 16'h1234);
    wr(3'h1, 16'h00a5);
    rdc(3'h1, 16'h00a5);
    wr(3'h5, 16'hffff);
    rdc(3'h5, 16'h0000);
    wr(3'h6, 16'hff03);
    wr(3'h7, 16'hab01);
    wr(3'h4, 16'h0030);
    rdc(3'h6, 16'h0303);
    rdc(3'h7, 16'h0101);
    wr(3'h7, 16'h0000);
    repeat (4) begin
      {q, r} = $random(seed);
      p = {13'h0, r[2:0]} + 16'h1;
      d = {14'h0, r[4:3]};
      wr(3'h2, p);
      wr(3'h3, 16'h0000);
      wr(3'h6, d);
      wr(3'h4, 16'h4030);
      wr(3'h4, 16'h4000);
      waitIrq(n);
      waitIrq(n);
      chk(n[15:0], expGap(p, d));
    end
    wr(3'h4, 16'h4010);
    rdc(3'h4, 16'hc010);
    wr(3'h4, 16'h4010);
    rdc(3'h4, 16'hc010);
    wr(3'h4, 16'hc010);
    rdc(3'h4, 16'h4010);
    wr(3'h4, 16'h0000);
    q = 16'h0;
    repeat (40) begin
      @(posedge core_clk);
      if (zeroIrq !== 1'b0) q = 16'h1;
    end
    chk(q, 16'h0000);
    rdc(3'h4, 16'h8000);
    wr(3'h6, 16'h0000);
    wr(3'h2, 16'h0040);
    wr(3'h4, 16'h0020);
    debugHalt <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(3'h0, r);
    rd(3'h0, q);
    chk(q, r);
    wr(3'h4, 16'h0c20);
    rdc(3'h4, 16'h8c00);
    rd(3'h0, r);
    rd(3'h0, q);
    chk(r - q, 16'h0002);
    wr(3'h4, 16'h4420);
    waitIrq(n);
    repeat (2) @(posedge core_clk);
    rdc(3'h0, 16'h0000);
    rdc(3'h1, 16'h0000);
    debugHalt <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(3'h0, r);
    rd(3'h0, q);
    chk(r - q, 16'h0002);
    results();
  end
endmodule
`default_nettype wire
